// ### src/fault_regs_defs.svh
`ifndef FAULT_REGS_DEFS_SVH
`define FAULT_REGS_DEFS_SVH

// Register byte offsets
`define OFS_FSR        8'h00
`define OFS_RESTORE    8'h04
`define OFS_RESUME     8'h08
`define OFS_SYN_FIRST  8'h0C
`define OFS_SYN_SECOND 8'h10
`define OFS_ATTR_LOW   8'h14
`define OFS_ATTR_HIGH  8'h18
`define OFS_NMREMAP    8'h1C
`define OFS_BANK_CFG   8'h20

// Fault status fields
`define FSR_SS_BIT     30
`define FSR_FMT_LSB    8
`define FSR_FMT_MASK   32'h00000300
`define FSR_SS_MASK    32'h40000000
`define FSR_FAULT_MASK 32'h000000FE

// First syndrome fields
`define SYN_S1IDX_LSB  16
`define SYN_AFR_BIT    11
`define SYN_WALK_EXTERNAL_FAULT_FLAG_BIT   10
`define SYN_NS_BIT     8
`define SYN_IND_BIT    6
`define SYN_PNU_BIT    5
`define SYN_WNR_BIT    4

// Bank configuration fields
`define CFG_S2FMT_BIT  0
`define CFG_SECURE_BIT 1
`define CFG_SCHEME_LSB 2

// Stored width of the stage-one bank index
`define S1_IDX_W       4
`define NESTED_CAP     1'b1
`define RESET_WORD     32'h00000000

`endif

// ### src/fault_regs_pkg.sv
package fault_regs_pkg;
`include "fault_regs_defs.svh"

    typedef enum logic [1:0] {
        SCHEME_SHORT32,
        SCHEME_LONG32,
        SCHEME_LONG64
    } scheme_t;

    typedef enum logic [2:0] {
        FK_WALK,
        FK_TRANSLATION,
        FK_ACCESS,
        FK_PERMISSION,
        FK_OTHER
    } fault_kind_t;

    typedef struct packed {
        logic                 ack;
        logic [31:0]          rdata;
        logic [31:0]          fsr;
        logic [`S1_IDX_W-1:0] s1idx;
        logic                 async_recorded_flag;
        logic                 walk_external_fault_flag;
        logic                 security_attr_flag;
        logic                 instr_fetch_flag;
        logic                 privileged_flag;
        logic                 write_access_flag;
        logic [1:0]           fault_table_level;
        logic [31:0]          syn_second;
        logic [31:0]          attr_low;
        logic [31:0]          attr_high;
        logic [31:0]          nmremap;
        logic [3:0]           cfg;
        logic                 resume;
    } regs_t;

    typedef struct packed {
        logic [7:0] mem_attr;
        logic [1:0] inner;
        logic [1:0] outer;
        logic       indirect;
    } lookup_t;

    // Byte-lane merge of a bus write
    function automatic logic [31:0] wb_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Stream override: 0x pass, 10 force 0, 11 force 1
    function automatic logic apply_ovr(input logic [1:0] ovr, input logic v);
        return ovr[1] ? ovr[0] : v;
    endfunction
endpackage

// ### src/attr_lookup.sv
`timescale 1ns/1ps
`default_nettype none
module attr_lookup (
    input  wire logic                     clk_i,
    input  wire logic                     rst_i,
    input  wire fault_regs_pkg::scheme_t  scheme_i,
    input  wire logic [2:0]               attr_index_i,
    input  wire logic [31:0]              attr_low_i,
    input  wire logic [31:0]              attr_high_i,
    input  wire logic [31:0]              nmremap_i,
    input  wire logic [7:0]               region_normal_i,
    output logic [7:0]                    mem_attr_o,
    output logic [1:0]                    inner_cache_o,
    output logic [1:0]                    outer_cache_o,
    output logic                          indirect_o
);
    fault_regs_pkg::lookup_t st_r;
    fault_regs_pkg::lookup_t st_nxt;
    logic [63:0]             attr_pair;

    assign attr_pair = {attr_high_i, attr_low_i};

    // Long schemes index the attribute pair; the short scheme maps through nmremap
    always_comb begin
        st_nxt = st_r;
        st_nxt.indirect = (scheme_i != fault_regs_pkg::SCHEME_SHORT32);
        if (st_nxt.indirect) begin
            st_nxt.mem_attr = attr_pair[attr_index_i*8 +: 8];
            st_nxt.inner    = 2'h0;
            st_nxt.outer    = 2'h0;
        end else begin
            st_nxt.mem_attr = 8'h00;
            // Non-normal regions carry no cacheability mapping
            if (region_normal_i[attr_index_i]) begin
                st_nxt.outer = nmremap_i[16 + attr_index_i*2 +: 2];
                st_nxt.inner = nmremap_i[attr_index_i*2 +: 2];
            end else begin
                st_nxt.outer = 2'h0;
                st_nxt.inner = 2'h0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign mem_attr_o    = st_r.mem_attr;
    assign inner_cache_o = st_r.inner;
    assign outer_cache_o = st_r.outer;
    assign indirect_o    = st_r.indirect;
endmodule
`default_nettype wire

// ### src/context_fault_syndrome_regs.sv
`include "fault_regs_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module context_fault_syndrome_regs (
    input  wire logic                        clk_i,
    input  wire logic                        rst_i,
    input  wire logic                        cyc_i,
    input  wire logic                        stb_i,
    input  wire logic                        we_i,
    input  wire logic [7:0]                  adr_i,
    input  wire logic [3:0]                  sel_i,
    input  wire logic [31:0]                 dat_i,
    output logic [31:0]                      dat_o,
    output logic                             ack_o,
    input  wire logic                        fault_valid_i,
    input  wire logic [7:0]                  fault_type_i,
    input  wire logic                        fault_stall_i,
    input  wire logic                        fault_async_i,
    input  wire fault_regs_pkg::fault_kind_t fault_kind_i,
    input  wire logic                        walk_ext_fault_i,
    input  wire logic                        walk_disabled_i,
    input  wire logic [1:0]                  level_i,
    input  wire logic [1:0]                  final_level_i,
    input  wire logic                        ns_attr_i,
    input  wire logic                        instr_i,
    input  wire logic                        priv_i,
    input  wire logic                        write_i,
    input  wire logic                        atomic_i,
    input  wire logic                        miss_read_i,
    input  wire logic                        miss_write_i,
    input  wire logic                        nested_i,
    input  wire logic [7:0]                  stage1_bank_index_i,
    input  wire logic [1:0]                  stream_security_override_i,
    input  wire logic [1:0]                  stream_instr_override_i,
    input  wire logic [1:0]                  stream_priv_override_i,
    input  wire logic [2:0]                  attr_index_i,
    input  wire logic [7:0]                  region_normal_i,
    output logic                             stalled_o,
    output logic                             fault_pending_o,
    output logic                             resume_o,
    output logic [7:0]                       mem_attr_o,
    output logic [1:0]                       inner_cache_o,
    output logic [1:0]                       outer_cache_o,
    output logic                             indirect_o
);
    fault_regs_pkg::regs_t   st_r;
    fault_regs_pkg::regs_t   st_nxt;
    fault_regs_pkg::scheme_t scheme;
    logic [31:0]             fsr_word;
    logic [31:0]             syn_word;
    logic [31:0]             merged;
    logic [31:0]             rd_word;
    logic [7:0]              word_adr;
    logic                    req;
    logic                    wr_now;
    logic                    idx_live;
    logic                    wnr_cap;

    // Level reported for a fault of a given kind
    function automatic logic [1:0] fault_level(input fault_regs_pkg::fault_kind_t k,
                                               input logic dis, input logic [1:0] lvl,
                                               input logic [1:0] fin,
                                               input fault_regs_pkg::scheme_t sch);
        logic [1:0] r;
        r = lvl;
        if (k == fault_regs_pkg::FK_PERMISSION) begin
            r = fin;
        end else if (k == fault_regs_pkg::FK_TRANSLATION && dis) begin
            r = (sch == fault_regs_pkg::SCHEME_LONG64) ? 2'h0 : 2'h1;
        end
        return r;
    endfunction

    assign word_adr = {adr_i[7:2], 2'h0};
    assign scheme   = fault_regs_pkg::scheme_t'(st_r.cfg[`CFG_SCHEME_LSB +: 2]);
    assign req      = cyc_i & stb_i;
    // Writes land on the edge where the master sees ack
    assign wr_now   = req & we_i & st_r.ack;
    // Index is kept only in stage-two banks of a nesting unit
    assign idx_live = st_r.cfg[`CFG_S2FMT_BIT] & `NESTED_CAP;

    // Format field is derived, never stored
    assign fsr_word = st_r.fsr | ({30'h0, scheme} << `FSR_FMT_LSB);

    // Reassemble the first syndrome word; reserved bits read zero
    always_comb begin
        syn_word = 32'h00000000;
        syn_word[`SYN_S1IDX_LSB +: `S1_IDX_W] = st_r.s1idx;
        syn_word[`SYN_AFR_BIT]  = st_r.async_recorded_flag;
        syn_word[`SYN_WALK_EXTERNAL_FAULT_FLAG_BIT] = st_r.walk_external_fault_flag;
        syn_word[`SYN_NS_BIT]   = st_r.security_attr_flag & st_r.cfg[`CFG_SECURE_BIT];
        syn_word[`SYN_IND_BIT]  = st_r.instr_fetch_flag;
        syn_word[`SYN_PNU_BIT]  = st_r.privileged_flag;
        syn_word[`SYN_WNR_BIT]  = st_r.write_access_flag;
        syn_word[1:0]           = st_r.fault_table_level;
    end

    // Read mux; restore and resume registers read as zero
    always_comb begin
        unique case (word_adr)
            `OFS_FSR:        rd_word = fsr_word;
            `OFS_SYN_FIRST:  rd_word = syn_word;
            `OFS_SYN_SECOND: rd_word = st_r.syn_second;
            `OFS_ATTR_LOW:   rd_word = st_r.attr_low;
            `OFS_ATTR_HIGH:  rd_word = st_r.attr_high;
            `OFS_NMREMAP:    rd_word = st_r.nmremap;
            `OFS_BANK_CFG:   rd_word = {28'h0, st_r.cfg};
            default:         rd_word = 32'h00000000;
        endcase
    end

    // Atomics name the missing permission; both or other give read
    assign wnr_cap = atomic_i ? (miss_write_i & ~miss_read_i) : write_i;

    // Software writes first, fault capture after so a fault beats a write
    always_comb begin
        st_nxt        = st_r;
        st_nxt.ack    = req & ~st_r.ack;
        st_nxt.resume = 1'b0;
        merged        = 32'h00000000;
        if (req & ~st_r.ack & ~we_i) begin
            st_nxt.rdata = rd_word;
        end else if (~req) begin
            st_nxt.rdata = 32'h00000000;
        end
        if (wr_now) begin
            unique case (word_adr)
                `OFS_RESTORE: begin
                    merged = fault_regs_pkg::wb_merge(fsr_word, dat_i, sel_i);
                    // Format and stall bits ignore the written value
                    st_nxt.fsr = (merged & ~(`FSR_FMT_MASK | `FSR_SS_MASK))
                               | (st_r.fsr & `FSR_SS_MASK);
                end
                `OFS_RESUME: begin
                    st_nxt.fsr[`FSR_SS_BIT] = 1'b0;
                    st_nxt.resume = 1'b1;
                end
                `OFS_SYN_FIRST: begin
                    merged = fault_regs_pkg::wb_merge(syn_word, dat_i, sel_i);
                    if (idx_live) begin
                        st_nxt.s1idx = merged[`SYN_S1IDX_LSB +: `S1_IDX_W];
                    end
                    st_nxt.async_recorded_flag    = merged[`SYN_AFR_BIT];
                    st_nxt.walk_external_fault_flag   = merged[`SYN_WALK_EXTERNAL_FAULT_FLAG_BIT];
                    st_nxt.security_attr_flag = merged[`SYN_NS_BIT];
                    st_nxt.instr_fetch_flag    = merged[`SYN_IND_BIT];
                    st_nxt.privileged_flag    = merged[`SYN_PNU_BIT];
                    st_nxt.write_access_flag    = merged[`SYN_WNR_BIT];
                    st_nxt.fault_table_level   = merged[1:0];
                end
                `OFS_SYN_SECOND: begin
                    st_nxt.syn_second = fault_regs_pkg::wb_merge(st_r.syn_second, dat_i, sel_i);
                end
                `OFS_ATTR_LOW: begin
                    st_nxt.attr_low = fault_regs_pkg::wb_merge(st_r.attr_low, dat_i, sel_i);
                end
                `OFS_ATTR_HIGH: begin
                    st_nxt.attr_high = fault_regs_pkg::wb_merge(st_r.attr_high, dat_i, sel_i);
                end
                `OFS_NMREMAP: begin
                    st_nxt.nmremap = fault_regs_pkg::wb_merge(st_r.nmremap, dat_i, sel_i);
                end
                `OFS_BANK_CFG: begin
                    merged = fault_regs_pkg::wb_merge({28'h0, st_r.cfg}, dat_i, sel_i);
                    st_nxt.cfg = merged[3:0];
                end
                default: begin
                end
            endcase
        end
        // Fault capture
        if (fault_valid_i) begin
            st_nxt.fsr = st_nxt.fsr | ({24'h0, fault_type_i} & `FSR_FAULT_MASK);
            if (fault_stall_i) begin
                st_nxt.fsr[`FSR_SS_BIT] = 1'b1;
            end
            // Only the low bits of the bank number are kept
            st_nxt.s1idx  = (idx_live & nested_i)
                          ? stage1_bank_index_i[`S1_IDX_W-1:0] : st_r.s1idx;
            st_nxt.async_recorded_flag    = fault_async_i;
            st_nxt.walk_external_fault_flag   = walk_ext_fault_i & (fault_kind_i == fault_regs_pkg::FK_WALK);
            st_nxt.security_attr_flag = fault_regs_pkg::apply_ovr(stream_security_override_i, ns_attr_i);
            st_nxt.instr_fetch_flag    = fault_regs_pkg::apply_ovr(stream_instr_override_i, instr_i);
            st_nxt.privileged_flag    = fault_regs_pkg::apply_ovr(stream_priv_override_i, priv_i);
            st_nxt.write_access_flag    = wnr_cap;
            st_nxt.fault_table_level   = fault_level(fault_kind_i, walk_disabled_i, level_i,
                                        final_level_i, scheme);
        end
        if (~idx_live) begin
            st_nxt.s1idx = '0;
        end
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign ack_o           = st_r.ack;
    assign dat_o           = st_r.rdata;
    assign stalled_o       = st_r.fsr[`FSR_SS_BIT];
    assign fault_pending_o = |(st_r.fsr & `FSR_FAULT_MASK);
    assign resume_o        = st_r.resume;

    // Attribute lookup for the walk
    attr_lookup u_lookup (
        .clk_i           (clk_i),
        .rst_i           (rst_i),
        .scheme_i        (scheme),
        .attr_index_i    (attr_index_i),
        .attr_low_i      (st_r.attr_low),
        .attr_high_i     (st_r.attr_high),
        .nmremap_i       (st_r.nmremap),
        .region_normal_i (region_normal_i),
        .mem_attr_o      (mem_attr_o),
        .inner_cache_o   (inner_cache_o),
        .outer_cache_o   (outer_cache_o),
        .indirect_o      (indirect_o)
    );

    // Checks
    chk_restore_keeps_ss: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_now && word_adr == `OFS_RESTORE && !fault_valid_i |=> $stable(stalled_o))
        else $error("restore write changed stall bit");
    chk_restore_loads: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_now && word_adr == `OFS_RESTORE && sel_i == 4'hF && !fault_valid_i
        |=> (st_r.fsr & ~`FSR_SS_MASK) == ($past(dat_i) & ~(`FSR_SS_MASK | `FSR_FMT_MASK)))
        else $error("restore write did not load status");
    chk_ss_only_resume: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(stalled_o) |-> $past(wr_now) && $past(word_adr) == `OFS_RESUME)
        else $error("stall bit cleared without resume");
    chk_restore_reads_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        req && !we_i && !ack_o && word_adr == `OFS_RESTORE |=> ack_o && dat_o == 32'h00000000)
        else $error("restore register returned data");
    chk_async_flag: assert property (@(posedge clk_i) disable iff (rst_i)
        fault_valid_i |=> st_r.async_recorded_flag == $past(fault_async_i))
        else $error("async flag wrong after fault");
    chk_walk_flag: assert property (@(posedge clk_i) disable iff (rst_i)
        fault_valid_i && fault_kind_i != fault_regs_pkg::FK_WALK |=> !st_r.walk_external_fault_flag)
        else $error("walk flag set for non-walk fault");
    chk_write_flag: assert property (@(posedge clk_i) disable iff (rst_i)
        fault_valid_i && !atomic_i |=> st_r.write_access_flag == $past(write_i))
        else $error("write flag mismatch");
    chk_atomic_both: assert property (@(posedge clk_i) disable iff (rst_i)
        fault_valid_i && atomic_i && miss_read_i |=> !st_r.write_access_flag)
        else $error("atomic fault must show read");
    chk_disabled_level: assert property (@(posedge clk_i) disable iff (rst_i)
        fault_valid_i && fault_kind_i == fault_regs_pkg::FK_TRANSLATION && walk_disabled_i
        |=> st_r.fault_table_level == ((scheme == fault_regs_pkg::SCHEME_LONG64) ? 2'h0 : 2'h1))
        else $error("disabled walk level wrong");
    chk_perm_level: assert property (@(posedge clk_i) disable iff (rst_i)
        fault_valid_i && fault_kind_i == fault_regs_pkg::FK_PERMISSION
        |=> st_r.fault_table_level == $past(final_level_i))
        else $error("permission level not final level");
    chk_index_gated: assert property (@(posedge clk_i) disable iff (rst_i)
        !idx_live |=> st_r.s1idx == '0)
        else $error("index kept in stage-one bank");
    chk_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
        req && !ack_o |=> ack_o ##1 !ack_o)
        else $error("ack not a single cycle");

    cov_fault: cover property (@(posedge clk_i) disable iff (rst_i) fault_valid_i && fault_stall_i);
    cov_restore: cover property (@(posedge clk_i) disable iff (rst_i) wr_now && word_adr == `OFS_RESTORE);
    cov_resume: cover property (@(posedge clk_i) disable iff (rst_i) $fell(stalled_o));
    cov_syn_read: cover property (@(posedge clk_i) disable iff (rst_i)
        ack_o && !we_i && word_adr == `OFS_SYN_FIRST);
endmodule
`default_nettype wire

// ### sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "fault_regs_defs.svh"
module tb;
    logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, fault_valid_i, fault_stall_i, fault_async_i;
    logic        walk_ext_fault_i, walk_disabled_i, ns_attr_i, instr_i, priv_i, write_i, atomic_i;
    logic        miss_read_i, miss_write_i, nested_i, stalled_o, fault_pending_o, resume_o, indirect_o;
    logic [7:0]  adr_i, fault_type_i, stage1_bank_index_i, region_normal_i, mem_attr_o;
    logic [3:0]  sel_i;
    logic [31:0] dat_i, dat_o, q;
    logic [1:0]  level_i, final_level_i, stream_security_override_i, stream_instr_override_i;
    logic [1:0]  stream_priv_override_i, inner_cache_o, outer_cache_o;
    logic [2:0]  attr_index_i;
    logic [63:0] attr_pair;
    fault_regs_pkg::fault_kind_t fault_kind_i;
    int          err_count, cmp_count, resume_seen;
    typedef struct {logic [7:0] adr; logic [31:0] wd; logic [31:0] rd;} row_t;
    row_t        rows [7];

    context_fault_syndrome_regs dut (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
        .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .fault_valid_i(fault_valid_i), .fault_type_i(fault_type_i),
        .fault_stall_i(fault_stall_i), .fault_async_i(fault_async_i), .fault_kind_i(fault_kind_i),
        .walk_ext_fault_i(walk_ext_fault_i), .walk_disabled_i(walk_disabled_i), .level_i(level_i),
        .final_level_i(final_level_i), .ns_attr_i(ns_attr_i), .instr_i(instr_i), .priv_i(priv_i),
        .write_i(write_i), .atomic_i(atomic_i), .miss_read_i(miss_read_i), .miss_write_i(miss_write_i),
        .nested_i(nested_i), .stage1_bank_index_i(stage1_bank_index_i),
        .stream_security_override_i(stream_security_override_i), .stream_instr_override_i(stream_instr_override_i),
        .stream_priv_override_i(stream_priv_override_i), .attr_index_i(attr_index_i),
        .region_normal_i(region_normal_i), .stalled_o(stalled_o), .fault_pending_o(fault_pending_o),
        .resume_o(resume_o), .mem_attr_o(mem_attr_o), .inner_cache_o(inner_cache_o),
        .outer_cache_o(outer_cache_o), .indirect_o(indirect_o)
    );

    // 200 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    // Counts resume pulses so a stuck or doubled pulse shows up
    always @(posedge clk_i) begin
        if (resume_o === 1'b1) begin
            resume_seen <= resume_seen + 1;
        end
    end

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Classic single cycle; waits for ack with a bound, takes data at the ack edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= 4'hF;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 40);
        chk("bus ack", 32'h1, {31'h0, ack_o});
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
        wb(1'b0, a, 32'h0);
        chk(nm, exp, q);
    endtask

    // c = stall,async,walk ext,walk off,nested; lv = level,final; a = ns,ins,prv,wr,atom,miss rd,miss wr
    task automatic flt(input fault_regs_pkg::fault_kind_t k, input logic [7:0] t, input logic [4:0] c,
                       input logic [3:0] lv, input logic [6:0] a, input logic [7:0] ix, input logic [5:0] ov);
        @(posedge clk_i);
        fault_valid_i <= 1'b1;
        fault_kind_i  <= k;
        fault_type_i  <= t;
        {fault_stall_i, fault_async_i, walk_ext_fault_i, walk_disabled_i, nested_i} <= c;
        {level_i, final_level_i} <= lv;
        {ns_attr_i, instr_i, priv_i, write_i, atomic_i, miss_read_i, miss_write_i} <= a;
        stage1_bank_index_i <= ix;
        {stream_security_override_i, stream_instr_override_i, stream_priv_override_i} <= ov;
        @(posedge clk_i);
        fault_valid_i <= 1'b0;
    endtask

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Hang guard, far beyond the 150 or so cycles the run needs
    initial begin
        #100000;
        err_count++;
        end_sim();
    end

    // Main sequence
    initial begin
        {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i, fault_valid_i, fault_type_i, fault_stall_i} = '0;
        {fault_async_i, walk_ext_fault_i, walk_disabled_i, level_i, final_level_i, ns_attr_i} = '0;
        {instr_i, priv_i, write_i, atomic_i, miss_read_i, miss_write_i, nested_i} = '0;
        {stage1_bank_index_i, stream_security_override_i, stream_instr_override_i} = '0;
        {stream_priv_override_i, attr_index_i, region_normal_i, resume_seen} = '0;
        fault_kind_i = fault_regs_pkg::FK_OTHER;
        rst_i = 1'b1;
        attr_pair = 64'h8899AABB_44FF0004;
        rows = '{'{`OFS_SYN_SECOND, 32'hA5A55A5A, 32'hA5A55A5A}, '{`OFS_ATTR_LOW, 32'h44FF0004, 32'h44FF0004},
                 '{`OFS_ATTR_HIGH, 32'h8899AABB, 32'h8899AABB}, '{`OFS_NMREMAP, 32'h12345678, 32'h12345678},
                 '{`OFS_RESTORE, 32'h0, 32'h0}, '{`OFS_RESUME, 32'h0, 32'h0}, '{8'h40, 32'hFFFFFFFF, 32'h0}};
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(`OFS_FSR, 32'h0, "status after reset");
        rd(`OFS_SYN_FIRST, 32'h0, "syndrome after reset");
        foreach (rows[i]) begin
            wb(1'b1, rows[i].adr, rows[i].wd);
            rd(rows[i].adr, rows[i].rd, $sformatf("register %h", rows[i].adr));
        end
        // Stage-two secure bank, 64-bit scheme; disabled walk gives level 0, ext flag ignored off-walk
        wb(1'b1, `OFS_BANK_CFG, 32'h0000000B);
        flt(fault_regs_pkg::FK_TRANSLATION, 8'h02, 5'b11111, 4'b1000, 7'b0111000, 8'hA7, 6'b111000);
        rd(`OFS_SYN_FIRST, 32'h00070930, "syndrome translation");
        rd(`OFS_FSR, 32'h40000202, "status after fault");
        // Walk fault with external error, atomic missing both permissions reads as read
        flt(fault_regs_pkg::FK_WALK, 8'h10, 5'b00101, 4'b1100, 7'b0101111, 8'h03, 6'b000000);
        rd(`OFS_SYN_FIRST, 32'h00030443, "syndrome walk");
        // Restore must leave stall and format alone
        wb(1'b1, `OFS_RESTORE, 32'h40000304);
        rd(`OFS_FSR, 32'h40000204, "status restored");
        wb(1'b1, `OFS_RESTORE, 32'h0);
        rd(`OFS_FSR, 32'h40000200, "status restore zero");
        chk("stall after restore", 32'h1, {31'h0, stalled_o});
        chk("pending after restore", 32'h0, {31'h0, fault_pending_o});
        wb(1'b1, `OFS_RESUME, 32'h0);
        repeat (2) @(posedge clk_i);
        chk("resume pulses", 32'd2, resume_seen);
        chk("stall after resume", 32'h0, {31'h0, stalled_o});
        rd(`OFS_FSR, 32'h00000200, "status after resume");
        // Stage-one non-secure bank: index and security bit read 0; atomic missing write shows write
        wb(1'b1, `OFS_BANK_CFG, 32'h00000004);
        flt(fault_regs_pkg::FK_PERMISSION, 8'h08, 5'b00001, 4'b1101, 7'b0000101, 8'h05, 6'b110000);
        rd(`OFS_SYN_FIRST, 32'h00000011, "syndrome permission");
        // Short scheme disabled walk reports level 1
        wb(1'b1, `OFS_BANK_CFG, 32'h00000000);
        flt(fault_regs_pkg::FK_TRANSLATION, 8'h02, 5'b00010, 4'b1100, 7'b0, 8'h0, 6'b0);
        rd(`OFS_SYN_FIRST, 32'h00000001, "syndrome short level");
        // Lookup: short scheme via remap with region 6 not normal, then long via indirection
        region_normal_i <= 8'hBF;
        for (int s = 0; s < 2; s++) begin
            wb(1'b1, `OFS_BANK_CFG, s == 0 ? 32'h0 : 32'h4);
            for (int i = 0; i < 8; i++) begin
                attr_index_i <= i[2:0];
                repeat (2) @(posedge clk_i);
                #1;
                chk("indirect", s, {31'h0, indirect_o});
                if (s == 0) begin
                    chk("inner", region_normal_i[i] ? 32'(rows[3].wd[2*i +: 2]) : 32'h0, 32'(inner_cache_o));
                    chk("outer", region_normal_i[i] ? 32'(rows[3].wd[16+2*i +: 2]) : 32'h0, 32'(outer_cache_o));
                end else begin
                    chk("attr", 32'(attr_pair[8*i +: 8]), 32'(mem_attr_o));
                end
            end
        end
        end_sim();
    end
endmodule
`default_nettype wire
